//--- dasrs_defs.vh
// Constants for the accumulator saturate, round and shift datapath
`ifndef DASRS_DEFS_VH
`define DASRS_DEFS_VH
`define DASRS_ACC_W 40
`define DASRS_WORD_W 16
`define DASRS_GUARD_HI 39
`define DASRS_GUARD_LO 32
`define DASRS_BIT31 31
`define DASRS_HIGH_LO 16
`define DASRS_MAX39 40'h7FFFFFFFF
`define DASRS_MIN39 40'h800000000
`define DASRS_MAX31 40'h007FFFFFF
`define DASRS_MIN31 40'h008000000
`define DASRS_HALF_LSW 16'h8000
`define DASRS_STORE_POS_LIM 25'h0007FFF
`define DASRS_STORE_NEG_LIM 25'h1FF8000
`define DASRS_STORE_MAX 16'h7FFF
`define DASRS_STORE_MIN 16'h8000
`define DASRS_WB_STEP 16'h0002
`define DASRS_MODE_CATA 2'h0
`define DASRS_MODE_BIT39 2'h1
`define DASRS_MODE_BIT31 2'h2
`define DASRS_KIND_MAC 3'h0
`define DASRS_KIND_MPY 3'h1
`define DASRS_KIND_MPYN 3'h2
`define DASRS_KIND_ED 3'h3
`define DASRS_KIND_EDAC 3'h4
`define DASRS_WB_DIRECT 1'b0
`define DASRS_WB_POSTINC 1'b1
`define DASRS_SHIFT_MAX 6'h10
`endif

//--- dasrs_shift.v
// Single-cycle 40-bit signed-amount barrel shifter
`timescale 1ns/1ns
`include "dasrs_defs.vh"
module dasrs_shift (
  input wire [39:0] i_acc_data,
  input wire [15:0] i_xbus_data,
  input wire i_from_xbus,
  input wire i_arith,
  input wire [5:0] i_amount,
  output reg [39:0] o_result,
  output reg [15:0] o_word
);
  reg [39:0] src;
  reg [5:0] mag;
  reg right;
  always @* begin
    right = ~i_amount[5];
    mag = right ? i_amount : (6'h00 - i_amount);
    if (mag > `DASRS_SHIFT_MAX) begin
      mag = `DASRS_SHIFT_MAX;
    end
    // X bus data sits high for right shifts so bits can fall into the low word
    if (i_from_xbus) begin
      src = right ? {{8{i_arith & i_xbus_data[15]}}, i_xbus_data, 16'h0000} :
                    {24'h000000, i_xbus_data};
    end else begin
      src = i_acc_data;
    end
    // Arithmetic shift stands alone: a mixed conditional would make it unsigned
    if (right && i_arith) begin
      o_result = $signed(src) >>> mag;
    end else if (right) begin
      o_result = src >> mag;
    end else begin
      o_result = src << mag;
    end
    o_word = right ? o_result[31:16] : o_result[15:0];
  end
endmodule

//--- dasrs_core.v
// Dual accumulator saturation, rounding, write-back and shift datapath
`timescale 1ns/1ns
`include "dasrs_defs.vh"
// Function
// - Update guard overflow flags on each adder operation
// - Guard overflow with trap enable requests trap
// - Sticky clipped flag on bit 31/39 overflow
// - Saturation off: clipped flag shows bit 39
// - Saturation off plus catastrophic enable requests trap
// - Combined OR of guard and clipped flags
// - Bit 39 mode clamps to 0x07FFFFFFFF and 0x0800000000
// - Bit 31 mode clamps to 0x0007FFFFFF and 0x0008000000
// - Bit 31 mode never sets guard flags
// - Catastrophic mode wraps, sets flag on bit 39
// - MAC forms except MPY, MPYN, ED and EDAC write back other accumulator
// - Direct write-back loads rounded word into pointer
// - Indirect write-back stores, then pointer plus two
// - Round select picks mode; none truncates
// - Conventional round increments on low >= 0x8000
// - Convergent: exact half rounds on bit 16
// - Store truncates, rounded store rounds, write-back rounds
// - Store clip: above 0x007FFF writes 0x7FFF
// - Store clip: below 0xFF8000 writes 0x8000
// - Clip off passes data; accumulator untouched
// - Shift up to 16, sign gives direction
// - 40-bit DSP result, 16-bit MCU result
// - Clip enables and clip point steer saturation
module dasrs_core (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_acc_a_clip_enable,
  input wire i_acc_b_clip_enable,
  input wire i_clip_point_select,
  input wire i_round_select,
  input wire i_store_clip_enable,
  input wire i_acc_a_ovf_trap_en,
  input wire i_acc_b_ovf_trap_en,
  input wire i_catastrophic_trap_en,
  input wire i_clip_clear_a,
  input wire i_clip_clear_b,
  input wire i_acc_op_valid,
  input wire i_acc_op_target,
  input wire i_acc_use_acc,
  input wire i_acc_sub,
  input wire [39:0] i_acc_operand,
  input wire [2:0] i_mac_kind,
  input wire i_wb_valid,
  input wire i_wb_mode,
  input wire [15:0] i_wb_ptr,
  input wire i_store_valid,
  input wire i_store_src,
  input wire i_store_round,
  input wire [15:0] i_store_addr,
  input wire i_shift_valid,
  input wire i_shift_src_acc,
  input wire i_shift_from_xbus,
  input wire i_shift_arith,
  input wire [5:0] i_shift_amount,
  input wire [15:0] i_xbus_rdata,
  output wire [39:0] o_accumulator_a,
  output wire [39:0] o_accumulator_b,
  output wire o_acc_a_guard_ovf,
  output wire o_acc_b_guard_ovf,
  output wire o_acc_a_clipped_flag,
  output wire o_acc_b_clipped_flag,
  output reg o_either_guard_ovf,
  output reg o_either_clipped,
  output reg o_arith_trap_req,
  output reg o_xbus_we,
  output reg [15:0] o_xbus_addr,
  output reg [15:0] o_xbus_wdata,
  output reg o_wptr_we,
  output reg [15:0] o_wptr_wdata,
  output reg o_shift_done,
  output reg [39:0] o_shift_result,
  output reg [15:0] o_shift_word
);
  // Saturation mode for one accumulator
  function [1:0] acc_mode;
    input clip_en;
    input point_sel;
    begin
      if (!clip_en) begin
        acc_mode = `DASRS_MODE_CATA;
      end else if (point_sel) begin
        acc_mode = `DASRS_MODE_BIT31;
      end else begin
        acc_mode = `DASRS_MODE_BIT39;
      end
    end
  endfunction

  // High word plus round increment, sign-extended to 25 bits for clip tests
  function [24:0] round_word;
    input [39:0] acc;
    input conv;
    input do_round;
    reg inc;
    begin
      inc = do_round & acc[15];
      if (conv && acc[15:0] == `DASRS_HALF_LSW && !acc[16]) begin
        inc = 1'b0;
      end
      round_word = {acc[39], acc[39:16]} + {24'h000000, inc};
    end
  endfunction

  // Data space write saturation, keyed on the source sign bit
  function [15:0] clip_store;
    input [24:0] val;
    input sign;
    input en;
    begin
      clip_store = val[15:0];
      if (en && !sign && $signed(val) > $signed(`DASRS_STORE_POS_LIM)) begin
        clip_store = `DASRS_STORE_MAX;
      end else if (en && sign && $signed(val) < $signed(`DASRS_STORE_NEG_LIM)) begin
        clip_store = `DASRS_STORE_MIN;
      end
    end
  endfunction

  // Reset asserts at once but releases on an edge, so no flop sees a runt release
  reg [1:0] rst_sync_ff;
  wire rst_n_int;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_ff[1];

  wire [1:0] clip_en_vec = {i_acc_b_clip_enable, i_acc_a_clip_enable};
  wire [1:0] trap_en_vec = {i_acc_b_ovf_trap_en, i_acc_a_ovf_trap_en};
  wire [1:0] clear_vec = {i_clip_clear_b, i_clip_clear_a};
  wire [1:0] nxt_guard_vec;
  wire [1:0] nxt_clip_vec;
  wire [1:0] trap_evt_vec;
  wire [39:0] acc_a_w;
  wire [39:0] acc_b_w;

  // One slice per accumulator: index 0 is A, index 1 is B
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_acc
      reg [39:0] acc_ff;
      reg guard_ff;
      reg clip_ff;
      reg [39:0] nxt_acc;
      reg nxt_guard;
      reg nxt_clip;
      reg clip_set;
      reg [39:0] lhs;
      reg [39:0] rhs;
      reg [39:0] sum;
      reg ovf39;
      reg ovf31;
      reg neg;
      wire hit = i_acc_op_valid & (i_acc_op_target == (g == 1));
      wire [1:0] mode = acc_mode(clip_en_vec[g], i_clip_point_select);
      always @* begin
        lhs = i_acc_use_acc ? acc_ff : 40'h0000000000;
        rhs = i_acc_sub ? ~i_acc_operand : i_acc_operand;
        sum = lhs + rhs + {39'h0000000000, i_acc_sub};
        // Like-signed inputs with an unlike-signed sum: the sign bit was lost
        ovf39 = (lhs[39] == rhs[39]) & (sum[39] != lhs[39]);
        // Bit 31 overflow: bits 39..31 are no longer all copies of the sign
        ovf31 = ovf39 | ~((&sum[39:31]) | ~(|sum[39:31]));
        // After a wrap the true sign is the inverse of the wrapped one
        neg = ovf39 ? ~sum[39] : sum[39];
        nxt_acc = acc_ff;
        clip_set = 1'b0;
        if (hit) begin
          nxt_acc = sum;
          case (mode)
            `DASRS_MODE_BIT39: begin
              if (ovf39) begin
                nxt_acc = neg ? `DASRS_MIN39 : `DASRS_MAX39;
                clip_set = 1'b1;
              end
            end
            `DASRS_MODE_BIT31: begin
              if (ovf31) begin
                nxt_acc = neg ? `DASRS_MIN31 : `DASRS_MAX31;
                clip_set = 1'b1;
              end
            end
            default: begin
              clip_set = ovf39;
            end
          endcase
        end
        // Guard flag tracks the newest result; bit 31 mode masks it outright
        if (hit) begin
          nxt_guard = ~((&nxt_acc[`DASRS_GUARD_HI:`DASRS_GUARD_LO]) |
                        ~(|nxt_acc[`DASRS_GUARD_HI:`DASRS_GUARD_LO]));
        end else begin
          nxt_guard = guard_ff;
        end
        if (mode == `DASRS_MODE_BIT31) begin
          nxt_guard = 1'b0;
        end
        // A set arriving with a clear wins
        nxt_clip = clip_set | (clip_ff & ~clear_vec[g]);
      end
      always @(posedge i_mclk or negedge rst_n_int) begin
        if (!rst_n_int) begin
          acc_ff <= 40'h0000000000;
          guard_ff <= 1'b0;
          clip_ff <= 1'b0;
        end else begin
          acc_ff <= nxt_acc;
          guard_ff <= nxt_guard;
          clip_ff <= nxt_clip;
        end
      end
      assign nxt_guard_vec[g] = nxt_guard;
      assign nxt_clip_vec[g] = nxt_clip;
      // Trap is an event pulse; a flag that merely stays set asks for nothing more
      assign trap_evt_vec[g] = (nxt_guard & ~guard_ff & trap_en_vec[g]) |
        (clip_set & (mode == `DASRS_MODE_CATA) & i_catastrophic_trap_en);
    end
  endgenerate

  assign acc_a_w = g_acc[0].acc_ff;
  assign acc_b_w = g_acc[1].acc_ff;
  assign o_accumulator_a = acc_a_w;
  assign o_accumulator_b = acc_b_w;
  assign o_acc_a_guard_ovf = g_acc[0].guard_ff;
  assign o_acc_b_guard_ovf = g_acc[1].guard_ff;
  assign o_acc_a_clipped_flag = g_acc[0].clip_ff;
  assign o_acc_b_clipped_flag = g_acc[1].clip_ff;

  // Store and write-back share the X bus; a store takes the cycle
  wire wb_kind_ok = (i_mac_kind != `DASRS_KIND_MPY) && (i_mac_kind != `DASRS_KIND_MPYN) &&
                    (i_mac_kind != `DASRS_KIND_ED) && (i_mac_kind != `DASRS_KIND_EDAC);
  wire wb_go = i_wb_valid & i_acc_op_valid & wb_kind_ok & ~i_store_valid;
  wire [39:0] store_src = i_store_src ? acc_b_w : acc_a_w;
  // Write-back reads the non-target accumulator as it stood before this edge
  wire [39:0] wb_src = i_acc_op_target ? acc_a_w : acc_b_w;
  wire [39:0] word_src = i_store_valid ? store_src : wb_src;
  wire word_round = i_store_valid ? i_store_round : 1'b1;
  // Rounding works on 25 bits so the clip test still sees a carry out of bit 39
  wire [24:0] word_rnd = round_word(word_src, i_round_select, word_round);
  wire [15:0] word_out = clip_store(word_rnd, word_src[39], i_store_clip_enable);

  wire [39:0] shift_res;
  wire [15:0] shift_word;
  // Shift reads the accumulator as it stood before the edge; result holds until the next shift
  dasrs_shift u_shift (
    .i_acc_data(i_shift_src_acc ? acc_b_w : acc_a_w),
    .i_xbus_data(i_xbus_rdata),
    .i_from_xbus(i_shift_from_xbus),
    .i_arith(i_shift_arith),
    .i_amount(i_shift_amount),
    .o_result(shift_res),
    .o_word(shift_word)
  );

  always @(posedge i_mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      o_either_guard_ovf <= 1'b0;
      o_either_clipped <= 1'b0;
      o_arith_trap_req <= 1'b0;
      o_xbus_we <= 1'b0;
      o_xbus_addr <= 16'h0000;
      o_xbus_wdata <= 16'h0000;
      o_wptr_we <= 1'b0;
      o_wptr_wdata <= 16'h0000;
      o_shift_done <= 1'b0;
      o_shift_result <= 40'h0000000000;
      o_shift_word <= 16'h0000;
    end else begin
      // OR bits follow the next flag values so they match the flags in the same cycle
      o_either_guard_ovf <= |nxt_guard_vec;
      o_either_clipped <= |nxt_clip_vec;
      o_arith_trap_req <= |trap_evt_vec;
      o_xbus_we <= 1'b0;
      o_wptr_we <= 1'b0;
      if (i_store_valid) begin
        o_xbus_we <= 1'b1;
        o_xbus_addr <= i_store_addr;
        o_xbus_wdata <= word_out;
      end else if (wb_go && i_wb_mode == `DASRS_WB_DIRECT) begin
        o_wptr_we <= 1'b1;
        o_wptr_wdata <= word_out;
      end else if (wb_go) begin
        o_xbus_we <= 1'b1;
        o_xbus_addr <= i_wb_ptr;
        o_xbus_wdata <= word_out;
        o_wptr_we <= 1'b1;
        o_wptr_wdata <= i_wb_ptr + `DASRS_WB_STEP;
      end
      o_shift_done <= i_shift_valid;
      if (i_shift_valid) begin
        o_shift_result <= shift_res;
        o_shift_word <= shift_word;
      end
    end
  end
endmodule

//--- dasrs_chk_sva.sv
// Assertion checker for the saturate round shift datapath
`timescale 1ns/1ns
module dasrs_chk (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_acc_a_clip_enable,
  input wire i_acc_b_clip_enable,
  input wire i_clip_point_select,
  input wire i_acc_a_ovf_trap_en,
  input wire i_clip_clear_a,
  input wire i_acc_op_valid,
  input wire i_store_valid,
  input wire i_shift_valid,
  input wire o_acc_a_guard_ovf,
  input wire o_acc_b_guard_ovf,
  input wire o_acc_a_clipped_flag,
  input wire o_acc_b_clipped_flag,
  input wire o_either_guard_ovf,
  input wire o_either_clipped,
  input wire o_arith_trap_req,
  input wire o_xbus_we,
  input wire o_shift_done
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_bit31;
    i_acc_a_clip_enable && i_acc_b_clip_enable && i_clip_point_select;
  endsequence
  sequence s_rise_a;
    $rose(o_acc_a_guard_ovf) && $past(i_acc_a_ovf_trap_en);
  endsequence
  guard_or_a: assert property (o_either_guard_ovf == (o_acc_a_guard_ovf | o_acc_b_guard_ovf))
    else $error("guard OR bit wrong");
  clip_or_a: assert property (o_either_clipped == (o_acc_a_clipped_flag | o_acc_b_clipped_flag))
    else $error("clipped OR bit wrong");
  no_guard31_a: assert property (s_bit31 ##1 s_bit31 |-> !o_either_guard_ovf)
    else $error("guard flag set in bit 31 mode");
  guard_trap_a: assert property (s_rise_a |-> o_arith_trap_req)
    else $error("no trap on guard overflow");
  clip_sticky_a: assert property (o_acc_a_clipped_flag && !i_clip_clear_a |=> o_acc_a_clipped_flag)
    else $error("clipped flag dropped");
  clip_clear_a: assert property (i_clip_clear_a && !i_acc_op_valid |=> !o_acc_a_clipped_flag)
    else $error("clipped flag not cleared");
  store_write_a: assert property (i_store_valid |=> o_xbus_we)
    else $error("store gave no write");
  shift_done_a: assert property (o_shift_done == $past(i_shift_valid))
    else $error("shift done mistimed");
endmodule

//--- dasrs_xbus_model.sv
// X data bus partner: keeps the last written word and serves it as read data
`timescale 1ns/1ns
module dasrs_xbus_model (
  input wire i_mclk,
  input wire i_we,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata
);
  initial o_rdata = 16'h0000;
  always @(posedge i_mclk) begin
    if (i_we) begin
      o_rdata <= i_wdata;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the saturate round shift datapath
`timescale 1ns/1ns
`include "dasrs_defs.vh"
module tb_top;
  reg i_mclk = 1'h0, i_rst_n = 1'h0, i_acc_a_clip_enable = 1'h0, i_acc_b_clip_enable = 1'h0;
  reg i_clip_point_select = 1'h0, i_round_select = 1'h0, i_store_clip_enable = 1'h0;
  reg i_acc_a_ovf_trap_en = 1'h0, i_acc_b_ovf_trap_en = 1'h0, i_catastrophic_trap_en = 1'h0;
  reg i_clip_clear_a = 1'h0, i_clip_clear_b = 1'h0, i_acc_op_valid = 1'h0;
  reg i_acc_op_target = 1'h0, i_acc_use_acc = 1'h0, i_acc_sub = 1'h0, i_wb_valid = 1'h0;
  reg i_wb_mode = 1'h0, i_store_valid = 1'h0, i_store_src = 1'h0, i_store_round = 1'h0;
  reg i_shift_valid = 1'h0, i_shift_src_acc = 1'h0, i_shift_from_xbus = 1'h0;
  reg i_shift_arith = 1'h0;
  reg [39:0] i_acc_operand = 40'h0;
  reg [2:0] i_mac_kind = 3'h0;
  reg [15:0] i_wb_ptr = 16'h0, i_store_addr = 16'h0800;
  reg [5:0] i_shift_amount = 6'h0;
  wire [15:0] i_xbus_rdata, o_xbus_addr, o_xbus_wdata, o_wptr_wdata, o_shift_word;
  wire [39:0] o_accumulator_a, o_accumulator_b, o_shift_result;
  wire o_acc_a_guard_ovf, o_acc_b_guard_ovf, o_acc_a_clipped_flag, o_acc_b_clipped_flag;
  wire o_either_guard_ovf, o_either_clipped, o_arith_trap_req, o_xbus_we, o_wptr_we;
  wire o_shift_done;
  integer err_count = 0;
  integer checks_done = 0;
  integer k;
  dasrs_core i_dut (.*);
  dasrs_xbus_model i_xmem (.i_mclk(i_mclk), .i_we(o_xbus_we), .i_wdata(o_xbus_wdata),
    .o_rdata(i_xbus_rdata));
  task automatic chkv(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
    chkv({24'h0, got}, {24'h0, exp});
  endtask
  task automatic chkb(input logic got, input logic exp);
    chkv({39'h0, got}, {39'h0, exp});
  endtask
  task automatic wrap_up;
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic op(input logic t, input logic u, input logic [39:0] d);
    @(negedge i_mclk);
    i_acc_op_valid = 1'h1;
    i_acc_op_target = t;
    i_acc_use_acc = u;
    i_acc_operand = d;
    @(negedge i_mclk);
    i_acc_op_valid = 1'h0;
  endtask
  task automatic st(input logic s, input logic r, input logic [15:0] exp);
    @(negedge i_mclk);
    i_store_valid = 1'h1;
    i_store_src = s;
    i_store_round = r;
    @(negedge i_mclk);
    i_store_valid = 1'h0;
    chkw(o_xbus_wdata, exp);
  endtask
  task automatic sh(input logic x, input logic [5:0] n, input logic [39:0] e, input logic [15:0] w);
    @(negedge i_mclk);
    i_shift_valid = 1'h1;
    i_shift_from_xbus = x;
    i_shift_amount = n;
    @(negedge i_mclk);
    i_shift_valid = 1'h0;
    chkv(o_shift_result, e);
    if (x) chkw(o_shift_word, w);
  endtask
  task automatic clr;
    @(negedge i_mclk);
    i_clip_clear_a = 1'h1;
    i_clip_clear_b = 1'h1;
    @(negedge i_mclk);
    i_clip_clear_a = 1'h0;
    i_clip_clear_b = 1'h0;
    chkb(o_either_clipped, 1'h0);
  endtask
  task automatic sc_sat;
    i_acc_a_ovf_trap_en = 1'h1;
    i_acc_b_ovf_trap_en = 1'h1;
    op(1'h0, 1'h0, 40'h4000000000);
    chkb(o_either_guard_ovf, 1'h1);
    chkb(o_arith_trap_req, 1'h1);
    chkb(o_acc_a_clipped_flag, 1'h0);
    op(1'h1, 1'h0, 40'hA000000000);
    chkb(o_arith_trap_req, 1'h1);
    i_acc_a_clip_enable = 1'h1;
    i_acc_b_clip_enable = 1'h1;
    op(1'h0, 1'h1, 40'h4000000000);
    chkv(o_accumulator_a, `DASRS_MAX39);
    op(1'h1, 1'h1, 40'hA000000000);
    chkv(o_accumulator_b, `DASRS_MIN39);
    clr;
    i_clip_point_select = 1'h1;
    op(1'h0, 1'h0, 40'h0080000000);
    chkv(o_accumulator_a, `DASRS_MAX31);
    op(1'h1, 1'h0, 40'hFF00000000);
    chkv(o_accumulator_b, `DASRS_MIN31);
    chkb(o_either_guard_ovf, 1'h0);
    chkb(o_acc_b_clipped_flag, 1'h1);
    clr;
    i_acc_a_clip_enable = 1'h0;
    i_acc_b_clip_enable = 1'h0;
    i_acc_a_ovf_trap_en = 1'h0;
    i_catastrophic_trap_en = 1'h1;
    op(1'h0, 1'h0, 40'h8000000000);
    i_acc_sub = 1'h1;
    op(1'h0, 1'h1, 40'h0000000001);
    i_acc_sub = 1'h0;
    chkv(o_accumulator_a, 40'h7FFFFFFFFF);
    chkb(o_acc_a_clipped_flag, 1'h1);
    chkb(o_arith_trap_req, 1'h1);
    clr;
  endtask
  task automatic sc_store;
    op(1'h0, 1'h0, 40'h0012348000);
    st(1'h0, 1'h0, 16'h1234);
    chkw(o_xbus_addr, 16'h0800);
    st(1'h0, 1'h1, 16'h1235);
    i_round_select = 1'h1;
    st(1'h0, 1'h1, 16'h1234);
    op(1'h0, 1'h0, 40'h0012358000);
    st(1'h0, 1'h1, 16'h1236);
    i_round_select = 1'h0;
    op(1'h0, 1'h0, 40'h0012347FFF);
    st(1'h0, 1'h1, 16'h1234);
    op(1'h0, 1'h0, 40'h0100000000);
    st(1'h0, 1'h0, 16'h0000);
    i_store_clip_enable = 1'h1;
    st(1'h0, 1'h0, 16'h7FFF);
    op(1'h0, 1'h0, 40'hFF00000000);
    st(1'h0, 1'h1, 16'h8000);
    chkv(o_accumulator_a, 40'hFF00000000);
    i_store_clip_enable = 1'h0;
  endtask
  task automatic sc_wb;
    op(1'h0, 1'h0, 40'h0012348000);
    i_wb_valid = 1'h1;
    op(1'h1, 1'h0, 40'h0000000000);
    chkb(o_wptr_we, 1'h1);
    chkw(o_wptr_wdata, 16'h1235);
    st(1'h1, 1'h0, 16'h0000);
    i_wb_mode = 1'h1;
    i_wb_ptr = 16'h0100;
    i_wb_valid = 1'h1;
    op(1'h1, 1'h0, 40'h0000000000);
    chkw(o_xbus_addr, 16'h0100);
    chkw(o_xbus_wdata, 16'h1235);
    chkw(o_wptr_wdata, 16'h0102);
    for (k = 1; k < 5; k = k + 1) begin
      i_mac_kind = k[2:0];
      i_wb_valid = 1'h1;
      op(1'h1, 1'h0, 40'h0000000000);
      chkb(o_wptr_we | o_xbus_we, 1'h0);
    end
    i_mac_kind = 3'h0;
    i_wb_valid = 1'h0;
  endtask
  task automatic sc_shift;
    op(1'h0, 1'h0, 40'h0012345678);
    i_shift_arith = 1'h1;
    sh(1'h0, 6'h04, 40'h0001234567, 16'h0);
    sh(1'h0, 6'h3C, 40'h0123456780, 16'h0);
    sh(1'h0, 6'h00, 40'h0012345678, 16'h0);
    sh(1'h0, 6'h10, 40'h0000001234, 16'h0);
    sh(1'h0, 6'h30, 40'h3456780000, 16'h0);
    i_shift_arith = 1'h0;
    sh(1'h1, 6'h04, 40'h0001235000, 16'h0123);
    sh(1'h1, 6'h3C, 40'h0000012350, 16'h2350);
    op(1'h1, 1'h0, 40'hF012345678);
    i_shift_src_acc = 1'h1;
    i_shift_arith = 1'h1;
    sh(1'h0, 6'h04, 40'hFF01234567, 16'h0);
    i_shift_src_acc = 1'h0;
  endtask
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (20) @(negedge i_mclk);
    i_rst_n = 1'h1;
    repeat (2) @(negedge i_mclk);
    sc_sat;
    sc_store;
    sc_wb;
    sc_shift;
    wrap_up;
  end
endmodule
bind dasrs_core dasrs_chk u_chk (.*);
